// ===== i2c_status_event_flags.sv
`timescale 1ns/1ps
`include "i2c_flags_defines.svh"
// Functional notes
// - Address flag from start until address received
// - Arbitration loss sets arbitration-lost flag
// - After loss keep clocking through ninth pulse
// - Arbitration-lost flag cleared only by software
// - Own address received sets slave-selected flag
// - Slave-selected reads zero when idle or master
// - Ninth bit captured into last-received bit
// - Busy set on start, cleared on stop
// - Busy reads zero while disabled
// - Data request set after each acknowledge bit as active master or selected slave
// - Buffer access clears data request if enabled
// - Auto clear disabled: only software clears it
// - Protocol request follows slave-selected or loss
// - Hold clock low after the ack pulse while any request pending, as active master or selected slave
// - Start request on busy bus loses arbitration
// - Ten-bit select chooses one or two bytes
// - Mode field: off, slave, master, multi-master
module i2c_status_event_flags
	import i2c_flags_pkg::*;
(
	// System
	input  wire logic        clk,
	input  wire logic        nrst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Two-wire bus
	input  wire logic        sclIn,
	output logic             sclOut,
	output logic             sclOe,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	// Interrupt
	output logic             irq
);
	logic        sclLevel;
	logic        sdaLevel;
	logic        sclRise;
	logic        sclFall;
	logic        startSeen;
	logic        stopSeen;
	logic [3:0]  bitCount;
	logic [7:0]  rxByte;
	logic        byteDone;
	logic        ackDone;
	logic        ackBit;

	mode_e       mode;
	logic        tenBit;
	logic        busyMaster;
	logic        autoClrDis;
	logic [9:0]  ownAddr;
	logic [6:0]  mask;
	logic [7:0]  buffer;
	logic [7:0]  txShift;
	logic        txMode;
	addr_state_e addrState;
	logic        arbLost;
	logic        lost;
	logic        slaveSel;
	logic        lastBit;
	logic        busBusy;
	logic        dataReq;
	logic        protoReq;
	logic        stretch;

	logic        enabled;
	logic        masterActive;
	logic        slaveCapable;
	logic        access;
	logic        wrCtrl;
	logic        wrStatus;
	logic        bufAccess;
	logic        setAl;
	logic        setSla;
	logic        busyRead;
	logic        slaRead;
	logic [6:0]  status;

	function automatic logic addrHit(input logic [15:0] a);
		addrHit = a == `CTRL_ADDR || a == `STATUS_ADDR || a == `BUFFER_ADDR ||
			a == `OWN_ADDR_ADDR || a == `MASK_ADDR;
	endfunction

	function automatic logic firstMatch(input logic [7:0] b, input logic ten,
		input logic [9:0] own);
		if (ten) begin
			firstMatch = b[7:3] == `TEN_BIT_HEADER && b[2:1] == own[9:8];
		end else begin
			firstMatch = b[7:1] == own[7:1];
		end
	endfunction

	i2c_line_monitor u_monitor (
		.clk       (clk),
		.nrst      (nrst),
		.sclPin    (sclIn),
		.sdaPin    (sdaIn),
		.sclLevel  (sclLevel),
		.sdaLevel  (sdaLevel),
		.sclRise   (sclRise),
		.sclFall   (sclFall),
		.startSeen (startSeen),
		.stopSeen  (stopSeen)
	);

	i2c_frame_counter u_counter (
		.clk      (clk),
		.nrst     (nrst),
		.restart  (startSeen || !enabled),
		.sclRise  (sclRise),
		.sdaLevel (sdaLevel),
		.bitCount (bitCount),
		.rxByte   (rxByte),
		.byteDone (byteDone),
		.ackDone  (ackDone),
		.ackBit   (ackBit)
	);

	assign enabled      = mode != MODE_OFF;
	assign masterActive = (mode == MODE_MASTER || mode == MODE_MULTI) && busyMaster;
	assign slaveCapable = (mode == MODE_SLAVE || mode == MODE_MULTI) && !busyMaster;
	assign access       = psel && penable;
	assign wrCtrl       = access && pwrite && paddr == `CTRL_ADDR;
	assign wrStatus     = access && pwrite && paddr == `STATUS_ADDR;
	assign bufAccess    = access && paddr == `BUFFER_ADDR;
	assign busyRead     = busBusy && enabled;
	assign slaRead      = slaveSel && busyRead && !masterActive;

	// Start request on a busy bus or a lost data bit
	assign setAl = (wrCtrl && pwdata[`CT_BUSY_MASTER] && !busyMaster && busyRead) ||
		(masterActive && !lost && txMode && sclRise && bitCount < `DATA_BITS &&
		txShift[7] && !sdaLevel);

	// Address byte matched while the address phase runs
	assign setSla = byteDone && !masterActive && ((addrState == ADDR_FIRST && !tenBit &&
		firstMatch(rxByte, 1'b0, ownAddr)) || (addrState == ADDR_SECOND &&
		rxByte == ownAddr[7:0]));

	assign status = {protoReq, dataReq, busyRead, lastBit, slaRead, arbLost,
		addrState == ADDR_FIRST || addrState == ADDR_SECOND};

	// APB: zero wait states, unmapped addresses flag an error
	assign pready  = 1'b1;
	assign pslverr = access && !addrHit(paddr);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			unique case (paddr)
				`CTRL_ADDR:     prdata <= {27'h000_0000, autoClrDis, busyMaster, tenBit, mode};
				`STATUS_ADDR:   prdata <= {25'h000_0000, status};
				`BUFFER_ADDR:   prdata <= {24'h00_0000, buffer};
				`OWN_ADDR_ADDR: prdata <= {22'h00_0000, ownAddr};
				`MASK_ADDR:     prdata <= {25'h000_0000, mask};
				default:        prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{autoClrDis, tenBit} <= 2'h0;
			mode    <= MODE_OFF;
			ownAddr <= `OWN_ADDR_RESET;
			mask    <= `MASK_RESET;
		end else if (access && pwrite) begin
			if (paddr == `CTRL_ADDR) begin
				mode       <= mode_e'(pwdata[`CT_MODE_HI:`CT_MODE_LO]);
				tenBit     <= pwdata[`CT_TEN_BIT];
				autoClrDis <= pwdata[`CT_AUTO_CLR_DIS];
			end
			if (paddr == `OWN_ADDR_ADDR) begin
				ownAddr <= pwdata[9:0];
			end
			if (paddr == `MASK_ADDR) begin
				mask <= pwdata[6:0];
			end
		end
	end

	// Busy master: refused on a busy bus, dropped after a lost frame
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busyMaster <= 1'b0;
		end else if (!enabled || mode == MODE_SLAVE) begin
			busyMaster <= 1'b0;
		end else if (wrCtrl) begin
			busyMaster <= pwdata[`CT_BUSY_MASTER] && (busyMaster || !busyRead);
		end else if (lost && ackDone) begin
			busyMaster <= 1'b0;
		end
	end

	// Loser keeps counting bits to the ninth pulse, driving nothing
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lost <= 1'b0;
		end else if (!enabled || ackDone || stopSeen) begin
			lost <= 1'b0;
		end else if (setAl && masterActive) begin
			lost <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			buffer <= 8'h00;
			txMode <= 1'b0;
		end else if (bufAccess && pwrite) begin
			buffer <= pwdata[7:0];
			txMode <= 1'b1;
		end else if (byteDone && !txMode) begin
			buffer <= rxByte;
		end else if (bufAccess) begin
			txMode <= 1'b0;
		end
	end

	// Released bits shift in as ones so the ack slot stays free
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			txShift <= 8'hFF;
		end else if (bufAccess && pwrite) begin
			txShift <= pwdata[7:0];
		end else if (sclFall && bitCount != 4'h0 && bitCount < `DATA_BITS) begin
			txShift <= {txShift[6:0], 1'b1};
		end else if (sclFall && bitCount == `DATA_BITS) begin
			txShift <= 8'hFF;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addrState <= ADDR_IDLE;
		end else if (!enabled || stopSeen) begin
			addrState <= ADDR_IDLE;
		end else if (startSeen) begin
			addrState <= slaveCapable ? ADDR_FIRST : ADDR_IDLE;
		end else if (byteDone) begin
			unique case (addrState)
				ADDR_FIRST:  addrState <= (tenBit && firstMatch(rxByte, 1'b1, ownAddr)) ?
					ADDR_SECOND : ADDR_DONE;
				ADDR_SECOND: addrState <= ADDR_DONE;
				ADDR_IDLE,
				ADDR_DONE:   addrState <= addrState;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			slaveSel <= 1'b0;
		end else if (!enabled || stopSeen || startSeen) begin
			slaveSel <= 1'b0;
		end else if (setSla) begin
			slaveSel <= 1'b1;
		end
	end

	// Set wins over a software clear in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			arbLost <= 1'b0;
		end else if (!enabled) begin
			arbLost <= 1'b0;
		end else if (setAl) begin
			arbLost <= 1'b1;
		end else if (wrStatus && pwdata[`ST_AL]) begin
			arbLost <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lastBit <= 1'b0;
		end else if (ackDone) begin
			lastBit <= ackBit;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busBusy <= 1'b0;
		end else if (!enabled || stopSeen) begin
			busBusy <= 1'b0;
		end else if (startSeen) begin
			busBusy <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dataReq <= 1'b0;
		end else if (!enabled) begin
			dataReq <= 1'b0;
		end else if (ackDone && (masterActive || slaveSel)) begin
			dataReq <= 1'b1;
		end else if (bufAccess && !autoClrDis) begin
			dataReq <= 1'b0;
		end else if (wrStatus && pwdata[`ST_DATA_EVENT_REQUEST]) begin
			dataReq <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			protoReq <= 1'b0;
		end else if (!enabled) begin
			protoReq <= 1'b0;
		end else if (setAl || setSla) begin
			protoReq <= 1'b1;
		end else if (wrStatus && pwdata[`ST_PROTOCOL_EVENT_REQUEST]) begin
			protoReq <= 1'b0;
		end
	end

	// Grab the clock only once low after the ack pulse, so the ack still clocks
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stretch <= 1'b0;
		end else if (!(dataReq || protoReq)) begin
			stretch <= 1'b0;
		end else if (!sclLevel && bitCount == `ACK_BIT &&
			((masterActive && !lost) || slaveSel)) begin
			stretch <= 1'b1;
		end
	end

	assign sclOut = 1'b0;
	assign sclOe  = stretch;
	assign sdaOut = 1'b0;
	assign sdaOe  = masterActive && !lost && txMode && bitCount < `DATA_BITS && !txShift[7];
	assign irq    = |(status & mask);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_lossSeen;
		masterActive && setAl;
	endsequence
	sequence s_frameEnds;
		ackDone && lost;
	endsequence

	property p_adrStart;
		startSeen && slaveCapable && enabled && !stopSeen |=> status[`ST_ADR];
	endproperty
	a_adrStart: assert property (p_adrStart) else $error("Address flag not set");

	property p_alSet;
		setAl && enabled |=> arbLost && protoReq;
	endproperty
	a_alSet: assert property (p_alSet) else $error("Loss not flagged");

	property p_lossRun;
		s_lossSeen |=> busyMaster && lost;
	endproperty
	a_lossRun: assert property (p_lossRun) else $error("Master stopped early");

	property p_lossEnd;
		(s_frameEnds and (enabled && !wrCtrl)) |=> !busyMaster && !lost;
	endproperty
	a_lossEnd: assert property (p_lossEnd) else $error("Loser kept mastership");

	property p_alSticky;
		arbLost && enabled && !(wrStatus && pwdata[`ST_AL]) |=> arbLost;
	endproperty
	a_alSticky: assert property (p_alSticky) else $error("Loss flag dropped");

	property p_slaIdle;
		!busyRead || masterActive |-> !slaRead;
	endproperty
	a_slaIdle: assert property (p_slaIdle) else $error("Selected flag while idle");

	property p_lrb;
		ackDone |=> lastBit == $past(ackBit);
	endproperty
	a_lrb: assert property (p_lrb) else $error("Ack bit not captured");

	property p_busy;
		startSeen && enabled ##1 !stopSeen && enabled |-> busyRead;
	endproperty
	a_busy: assert property (p_busy) else $error("Busy missing after start");

	property p_busyOff;
		!enabled |-> !busyRead && !slaRead;
	endproperty
	a_busyOff: assert property (p_busyOff) else $error("Busy while disabled");

	property p_irqdAuto;
		bufAccess && !autoClrDis && !ackDone |=> !dataReq;
	endproperty
	a_irqdAuto: assert property (p_irqdAuto) else $error("Auto clear failed");

	property p_irqdKeep;
		bufAccess && autoClrDis && dataReq && enabled && !wrStatus |=> dataReq;
	endproperty
	a_irqdKeep: assert property (p_irqdKeep) else $error("Request cleared by access");

	property p_release;
		!(dataReq || protoReq) |=> !sclOe;
	endproperty
	a_release: assert property (p_release) else $error("Clock held without request");

	property p_startBusy;
		wrCtrl && pwdata[`CT_BUSY_MASTER] && !busyMaster && busyRead && enabled &&
			mode != MODE_SLAVE |=> arbLost && !busyMaster;
	endproperty
	a_startBusy: assert property (p_startBusy) else $error("Start on busy bus");
endmodule // i2c_status_event_flags

// ===== i2c_flags_defines.svh
`ifndef I2C_FLAGS_DEFINES_SVH
`define I2C_FLAGS_DEFINES_SVH

// Register byte addresses
`define CTRL_ADDR        16'hED00
`define STATUS_ADDR      16'hED04
`define BUFFER_ADDR      16'hED08
`define OWN_ADDR_ADDR    16'hED0C
`define MASK_ADDR        16'hED10

// Status and mask field positions
`define ST_ADR           0
`define ST_AL            1
`define ST_SLA           2
`define ST_LRB           3
`define ST_BB            4
`define ST_DATA_EVENT_REQUEST          5
`define ST_PROTOCOL_EVENT_REQUEST          6

// Control field positions
`define CT_MODE_LO       0
`define CT_MODE_HI       1
`define CT_TEN_BIT       2
`define CT_BUSY_MASTER   3
`define CT_AUTO_CLR_DIS  4

// Reset values
`define CTRL_RESET       5'h00
`define OWN_ADDR_RESET   10'h000
`define MASK_RESET       7'h00

// Frame timing in bus clock pulses, and the ten-bit address header
`define DATA_BITS        4'h8
`define ACK_BIT          4'h9
`define TEN_BIT_HEADER   5'h1E

`endif

// ===== i2c_flags_pkg.sv
package i2c_flags_pkg;

	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_SLAVE,
		MODE_MASTER,
		MODE_MULTI
	} mode_e;

	typedef enum logic [1:0] {
		ADDR_IDLE,
		ADDR_FIRST,
		ADDR_SECOND,
		ADDR_DONE
	} addr_state_e;

endpackage

// ===== i2c_line_monitor.sv
`timescale 1ns/1ps
module i2c_line_monitor (
	// System
	input  wire logic clk,
	input  wire logic nrst,
	// Bus lines
	input  wire logic sclPin,
	input  wire logic sdaPin,
	// Conditioned view
	output logic      sclLevel,
	output logic      sdaLevel,
	output logic      sclRise,
	output logic      sclFall,
	output logic      startSeen,
	output logic      stopSeen
);
	logic [1:0] sclSync;
	logic [1:0] sdaSync;
	logic       sclPrev;
	logic       sdaPrev;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclSync <= 2'h3;
			sdaSync <= 2'h3;
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclSync <= {sclSync[0], sclPin};
			sdaSync <= {sdaSync[0], sdaPin};
			sclPrev <= sclSync[1];
			sdaPrev <= sdaSync[1];
		end
	end

	assign sclLevel  = sclSync[1];
	assign sdaLevel  = sdaSync[1];
	assign sclRise   = sclSync[1] && !sclPrev;
	assign sclFall   = !sclSync[1] && sclPrev;
	// Data moving while clock stays high marks start or stop
	assign startSeen = sclSync[1] && sclPrev && sdaPrev && !sdaSync[1];
	assign stopSeen  = sclSync[1] && sclPrev && !sdaPrev && sdaSync[1];
endmodule // i2c_line_monitor

// ===== i2c_frame_counter.sv
`timescale 1ns/1ps
`include "i2c_flags_defines.svh"
module i2c_frame_counter (
	// System
	input  wire logic       clk,
	input  wire logic       nrst,
	// Line events
	input  wire logic       restart,
	input  wire logic       sclRise,
	input  wire logic       sdaLevel,
	// Frame progress
	output logic [3:0]      bitCount,
	output logic [7:0]      rxByte,
	output logic            byteDone,
	output logic            ackDone,
	output logic            ackBit
);
	logic [3:0] next_bitCount;

	assign next_bitCount = (bitCount == `ACK_BIT) ? 4'h1 : bitCount + 4'h1;
	assign ackDone       = sclRise && next_bitCount == `ACK_BIT;
	assign ackBit        = sdaLevel;

	// One cycle late so the eighth bit has reached the shift register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			byteDone <= 1'b0;
		end else begin
			byteDone <= sclRise && next_bitCount == `DATA_BITS && !restart;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bitCount <= 4'h0;
		end else if (restart) begin
			bitCount <= 4'h0;
		end else if (sclRise) begin
			bitCount <= next_bitCount;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rxByte <= 8'h00;
		end else if (sclRise && next_bitCount <= `DATA_BITS) begin
			rxByte <= {rxByte[6:0], sdaLevel};
		end
	end
endmodule // i2c_frame_counter

// ===== i2c_bus_model.sv
`timescale 1ns/1ps
module i2c_bus_model (
	// Wire levels seen on the bus
	input  wire logic sclLine,
	input  wire logic sdaLine,
	// Pull-low drives, lines have pull-ups
	output logic      sclDrv,
	output logic      sdaDrv
);
	initial begin
		sclDrv = 1'b0;
		sdaDrv = 1'b0;
	end

	// SDA falls while SCL high
	task automatic start_cond();
		sdaDrv = 1'b1;
		#48;
	endtask

	// Nine pulses, MSB first, ninth bit is the acknowledge
	task automatic send_byte(input logic [7:0] b, input logic ack);
		logic bitVal;
		for (int i = 0; i < 9; i++) begin
			bitVal = (i < 8) ? b[7-i] : ack;
			sclDrv = 1'b1;
			#16 sdaDrv = !bitVal;
			#16 sclDrv = 1'b0;
			// Stretch: the device may hold SCL low
			wait (sclLine === 1'b1);
			#32;
		end
		// Clock stays low after the frame, as a real master keeps it
		sclDrv = 1'b1;
		#16 sdaDrv = 1'b0;
		#64;
	endtask

	// Next clock high phase; a device hold keeps the line low
	task automatic free_scl();
		sclDrv = 1'b0;
		#64;
	endtask

	// SDA rises while SCL high
	task automatic stop_cond();
		sclDrv = 1'b1;
		sdaDrv = 1'b1;
		#16 sclDrv = 1'b0;
		wait (sclLine === 1'b1);
		#16 sdaDrv = 1'b0;
		#48;
	endtask
endmodule // i2c_bus_model

// ===== i2c_status_event_flags_test.sv
`timescale 1ns/1ps
`include "i2c_flags_defines.svh"
module i2c_status_event_flags_test;
	logic        clk;
	logic        nrst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [15:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sclOut;
	logic        sclOe;
	logic        sdaOut;
	logic        sdaOe;
	logic        irq;
	logic        sclDrv;
	logic        sdaDrv;
	wire         sclLine = !(sclDrv | sclOe);
	wire         sdaLine = !(sdaDrv | sdaOe);
	int          fails;
	int          checksDone;
	int          seed;
	logic [7:0]  badAddr;
	logic [64:0] expQ[$];

	i2c_status_event_flags i_i2c_status_event_flags (
		.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));

	i2c_bus_model i_i2c_bus_model (
		.sclLine(sclLine), .sdaLine(sdaLine), .sclDrv(sclDrv), .sdaDrv(sdaDrv));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic got, input logic exp);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t pin level %b, expected %b", $time, got, exp);
		end
	endtask

	// Read data compare, fed by the queue in bus order
	always @(posedge clk) begin
		logic [64:0] e;
		if (psel && penable && pready && !pwrite) begin
			e = expQ.pop_front();
			checksDone++;
			if (((prdata & e[63:32]) !== e[31:0]) || (pslverr !== e[64])) begin
				fails++;
				$display("MISMATCH %0t read %h err %b, expected %h err %b",
					$time, prdata & e[63:32], pslverr, e[31:0], e[64]);
			end
		end
	end

	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic [31:0] m,
		input logic err);
		expQ.push_back({err, m, exp & m});
		apb(1'b0, a, 32'h0000_0000);
	endtask

	initial begin
		#500_000;
		fails++;
		$display("MISMATCH %0t watchdog expired", $time);
		wrap_up();
	end

	initial begin
		nrst    = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 16'h0000;
		pwdata  = 32'h0000_0000;
		seed    = 32'hc837_fd6f;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		rd(`STATUS_ADDR, 32'h0000_0000, 32'h0000_007F, 1'b0);
		rd(16'hED14, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
		// Disabled module ignores bus activity
		i_i2c_bus_model.start_cond();
		rd(`STATUS_ADDR, 32'h0000_0000, 32'h0000_0010, 1'b0);
		i_i2c_bus_model.stop_cond();
		apb(1'b1, `OWN_ADDR_ADDR, 32'h0000_00A0);
		apb(1'b1, `MASK_ADDR, 32'h0000_007F);
		apb(1'b1, `CTRL_ADDR, 32'h0000_0001);
		// Foreign address: not selected
		badAddr = 8'($random(seed));
		if (badAddr[7:1] == 7'h50) badAddr[1] = ~badAddr[1];
		i_i2c_bus_model.start_cond();
		rd(`STATUS_ADDR, 32'h0000_0011, 32'h0000_007F, 1'b0);
		i_i2c_bus_model.send_byte(badAddr, 1'b0);
		rd(`STATUS_ADDR, 32'h0000_0000, 32'h0000_0045, 1'b0);
		apb(1'b1, `STATUS_ADDR, 32'h0000_0060);
		i_i2c_bus_model.stop_cond();
		rd(`STATUS_ADDR, 32'h0000_0000, 32'h0000_0014, 1'b0);
		// Own address, auto clear on then off; ack bit differs per pass
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, `CTRL_ADDR, k ? 32'h0000_0011 : 32'h0000_0001);
			i_i2c_bus_model.start_cond();
			i_i2c_bus_model.send_byte(8'hA0, k == 1);
			i_i2c_bus_model.free_scl();
			rd(`STATUS_ADDR, k ? 32'h0000_007C : 32'h0000_0074,
				32'h0000_007F, 1'b0);
			chk(irq, 1'b1);
			chk(sclLine, 1'b0);
			rd(`BUFFER_ADDR, 32'h0000_00A0, 32'h0000_00FF, 1'b0);
			rd(`STATUS_ADDR, k ? 32'h0000_007C : 32'h0000_0054,
				32'h0000_007F, 1'b0);
			apb(1'b1, `MASK_ADDR, 32'h0000_0000);
			// Mask lands at this edge; look once it has settled
			@(negedge clk);
			chk(irq, 1'b0);
			apb(1'b1, `MASK_ADDR, 32'h0000_007F);
			apb(1'b1, `STATUS_ADDR, 32'h0000_0060);
			rd(`STATUS_ADDR, k ? 32'h0000_001C : 32'h0000_0014,
				32'h0000_007F, 1'b0);
			repeat (2) @(posedge clk);
			chk(sclLine, 1'b1);
			i_i2c_bus_model.stop_cond();
			rd(`STATUS_ADDR, 32'h0000_0000, 32'h0000_0074, 1'b0);
		end
		// Ten-bit addressing needs both bytes
		apb(1'b1, `OWN_ADDR_ADDR, 32'h0000_02A5);
		apb(1'b1, `CTRL_ADDR, 32'h0000_0005);
		i_i2c_bus_model.start_cond();
		i_i2c_bus_model.send_byte(8'hF4, 1'b0);
		rd(`STATUS_ADDR, 32'h0000_0001, 32'h0000_0005, 1'b0);
		apb(1'b1, `STATUS_ADDR, 32'h0000_0020);
		i_i2c_bus_model.send_byte(8'hA5, 1'b0);
		rd(`STATUS_ADDR, 32'h0000_0004, 32'h0000_0005, 1'b0);
		apb(1'b1, `STATUS_ADDR, 32'h0000_0060);
		i_i2c_bus_model.stop_cond();
		// Master loses its first data bit, clocks on to the ack, then steps back
		apb(1'b1, `CTRL_ADDR, 32'h0000_0002);
		apb(1'b1, `CTRL_ADDR, 32'h0000_000A);
		rd(`CTRL_ADDR, 32'h0000_000A, 32'h0000_000F, 1'b0);
		apb(1'b1, `BUFFER_ADDR, 32'h0000_00FF);
		i_i2c_bus_model.start_cond();
		i_i2c_bus_model.send_byte(8'h00, 1'b0);
		chk(sdaOe, 1'b0);
		rd(`STATUS_ADDR, 32'h0000_0052, 32'h0000_0056, 1'b0);
		rd(`CTRL_ADDR, 32'h0000_0000, 32'h0000_0008, 1'b0);
		apb(1'b1, `STATUS_ADDR, 32'h0000_0062);
		i_i2c_bus_model.stop_cond();
		// Start request on a busy bus, master and multi-master
		for (int m = 2; m < 4; m++) begin
			apb(1'b1, `CTRL_ADDR, m);
			i_i2c_bus_model.start_cond();
			apb(1'b1, `CTRL_ADDR, m | 8);
			rd(`CTRL_ADDR, 32'h0000_0000, 32'h0000_0008, 1'b0);
			rd(`STATUS_ADDR, 32'h0000_0052, 32'h0000_0056, 1'b0);
			chk(irq, 1'b1);
			apb(1'b1, `STATUS_ADDR, 32'h0000_0000);
			rd(`STATUS_ADDR, 32'h0000_0042, 32'h0000_0042, 1'b0);
			apb(1'b1, `STATUS_ADDR, 32'h0000_0042);
			rd(`STATUS_ADDR, 32'h0000_0000, 32'h0000_0042, 1'b0);
			i_i2c_bus_model.stop_cond();
		end
		repeat (4) @(posedge clk);
		wrap_up();
	end
endmodule // i2c_status_event_flags_test
